// ### logic/pmc_map.vh
// Purpose: constants of the i/o macrocell bank
// Assumes: avalon-mm byte addresses, word aligned
// Notes: register map and cell bit layout
// How it works
// RULE1 - cell one: 1 combinatorial, 0 stored; the code gives combinatorial output when cell three is 0
// RULE2 - cell zero: 1 inverts pin, 0 true
// RULE3 - cell two: 1 register, 0 latch
// RULE4 - cell three: 1 sum feeds, 0 pin feeds
// RULE5 - input cell stores pin, feeds array
// RULE6 - cell four: 1 dedicated, 0 shared timing
// RULE7 - cell five: 1 rising/low gate, else opposite
// RULE8 - low gate holds high, passes low
// RULE9 - cells six/seven pick buffer enable
// RULE10 - cell eight: 1 storage, 0 pin feedback
// RULE11 - eight cells single, eight dual feedback
// RULE12 - erased cell reads one, programmed zero
// RULE13 - power-up clears every storage element
// RULE14 - preload by term or supervoltage
// RULE15 - preload writes any state, clocking continues
// RULE16 - observe term drives storage onto pin
// RULE17 - security blocks program, verify, preload, observe
// RULE18 - only full erase clears security; the code also clears it on resetn
// RULE19 - set security after programming, verifying
// RULE20 - preset loads high, reset low, unclocked; the code applies them at the next ref_clk edge
// RULE21 - latch forcing only while holding
// RULE22 - dual cells feed pin and storage
// RULE23 - cells static, held in registers
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_CELLS       16
`define PMC_DUAL_CELLS  8
`define PMC_CFG_W       9
`define PMC_CFG_ERASED  9'h1ff
`define PMC_CFG_DUAL_MASK 9'h0ff
// cell bit positions inside a config word
`define PMC_B_POL       0
`define PMC_B_OTYPE     1
`define PMC_B_KIND      2
`define PMC_B_DIR       3
`define PMC_B_CSRC      4
`define PMC_B_CSENSE    5
`define PMC_B_BUF_HI    6
`define PMC_B_BUF_LO    7
`define PMC_B_FBSEL     8
// buffer control codes {hi,lo}
`define PMC_BUF_PIN     2'h3
`define PMC_BUF_XOR     2'h2
`define PMC_BUF_ON      2'h1
// register byte offsets
`define PMC_A_CFG_LAST  8'h3c
`define PMC_A_CTRL      8'h40
`define PMC_A_PRELOAD   8'h44
`define PMC_A_STATUS    8'h48
`define PMC_A_STORAGE   8'h4c
`define PMC_A_PINS      8'h50
// control register bits
`define PMC_C_SECURE    0
`define PMC_C_ERASE     1
`endif

// ### logic/pmc_macrocell_bank.v
// Purpose: bank of sixteen configurable i/o macrocells
// Assumes: all pins synchronous to ref_clk; timing pins sampled
// Notes: pin and array feedback outputs lag inputs by one clock, storage_fb lags stored by one
`include "pmc_map.vh"
`default_nettype none
module pmc_macrocell_bank (
   input  wire        ref_clk,
   input  wire        resetn,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire [15:0] sum_term,
   input  wire [15:0] pin_in,
   output reg  [15:0] pin_out,
   output reg  [15:0] pin_oe,
   output reg  [15:0] array_fb,
   output reg  [15:0] storage_fb,
   input  wire        dedicated_timing_pin,
   input  wire        shared_input_timing_pin,
   input  wire        common_oe_pin,
   input  wire [3:0]  bank_term_a,
   input  wire [3:0]  bank_term_b,
   input  wire        preset_term,
   input  wire        reset_term,
   input  wire        preload_term,
   input  wire        preload_hv,
   input  wire        observe_term,
   input  wire        observe_hv
);

   reg         secured;
   reg  [15:0] preload_value;
   reg  [15:0] stored;
   reg         prev_ded;
   reg         prev_shr;
   wire [`PMC_CELLS*`PMC_CFG_W-1:0] cfg_flat;
   wire [15:0] next_stored;
   wire [15:0] next_pin_out;
   wire [15:0] next_pin_oe;
   wire [15:0] next_array_fb;
   wire        bus_req;
   wire        wr_fire;
   wire        cfg_hit;
   wire [3:0]  cfg_idx;
   wire        erase_fire;
   wire        secure_fire;
   // preload and observe die once the part is locked
   wire        preload_fire = (preload_term | preload_hv) & ~secured; // RULE14 RULE17
   wire        observe_on   = (observe_term | observe_hv) & ~secured; // RULE16 RULE17

   assign bus_req = avs_read | avs_write;
   // a write lands on the edge where waitrequest is seen low
   assign wr_fire = avs_write & ~avs_waitrequest;
   assign cfg_hit = (avs_address <= `PMC_A_CFG_LAST) & (avs_address[1:0] == 2'h0);
   assign cfg_idx = avs_address[5:2];
   assign erase_fire  = wr_fire & (avs_address == `PMC_A_CTRL) & avs_byteenable[0]
                      & avs_writedata[`PMC_C_ERASE];
   assign secure_fire = wr_fire & (avs_address == `PMC_A_CTRL) & avs_byteenable[0]
                      & avs_writedata[`PMC_C_SECURE] & ~avs_writedata[`PMC_C_ERASE];

   // timing pin history for edge detection; not reset, so a pin held
   // high through reset gives no false edge on release
   always @(posedge ref_clk) begin
      prev_ded <= dedicated_timing_pin;
      prev_shr <= shared_input_timing_pin;
   end

   genvar i;
   generate
      for (i = 0; i < `PMC_CELLS; i = i + 1) begin : g_cell
         reg  [`PMC_CFG_W-1:0] cfg;
         wire       dual = (i < `PMC_DUAL_CELLS);
         wire [8:0] wmask = dual ? `PMC_CFG_DUAL_MASK : `PMC_CFG_ERASED; // RULE11
         wire       src  = cfg[`PMC_B_CSRC] ? dedicated_timing_pin : shared_input_timing_pin; // RULE6
         wire       prv  = cfg[`PMC_B_CSRC] ? prev_ded : prev_shr;
         wire       sense = cfg[`PMC_B_CSENSE];
         // rising with sense set, falling otherwise
         wire       edge_hit = sense ? (src & ~prv) : (~src & prv); // RULE7
         // low gate passes while low, high gate while high
         wire       open_gate = sense ? ~src : src; // RULE7 RULE8
         wire       is_reg = cfg[`PMC_B_KIND]; // RULE3
         // pin as source turns the cell into an input stage; the sum is
         // stored inverted so a cleared element shows the idle pin level
         wire       d = cfg[`PMC_B_DIR] ? ~sum_term[i] : pin_in[i]; // RULE4 RULE5
         wire [1:0] buf_sel = {cfg[`PMC_B_BUF_HI], cfg[`PMC_B_BUF_LO]};
         reg        ns;
         reg        oe;

         // config word: writes refused when locked, erase restores ones
         always @(posedge ref_clk) begin
            if (!resetn) begin
               cfg <= `PMC_CFG_ERASED & wmask; // RULE12
            end else if (erase_fire) begin
               cfg <= `PMC_CFG_ERASED & wmask; // RULE18
            end else if (wr_fire & cfg_hit & (cfg_idx == i) & ~secured) begin // RULE17
               if (avs_byteenable[0])
                  cfg[7:0] <= avs_writedata[7:0];
               if (avs_byteenable[1] & ~dual)
                  cfg[8] <= avs_writedata[8]; // RULE11
            end
         end

         // storage next state; a transparent latch ignores forcing
         always @* begin
            ns = stored[i];
            if (!is_reg && open_gate) begin
               ns = d; // RULE8 RULE21
            end else if (preload_fire) begin
               ns = preload_value[i]; // RULE15
            end else if (preset_term) begin
               ns = 1'b1; // RULE20
            end else if (reset_term) begin
               ns = 1'b0; // RULE20
            end else if (is_reg && edge_hit) begin
               ns = d; // RULE3
            end
         end

         // buffer enable selection per bank of four
         always @* begin
            case (buf_sel)
               `PMC_BUF_PIN: oe = common_oe_pin; // RULE9
               `PMC_BUF_XOR: oe = bank_term_a[i/4] ^ bank_term_b[i/4]; // RULE9
               `PMC_BUF_ON:  oe = 1'b1; // RULE9
               default:      oe = 1'b0; // RULE9
            endcase
         end

         assign next_stored[i] = ns;
         // observe forces stored data out regardless of output type
         assign next_pin_out[i] = (observe_on | (~cfg[`PMC_B_OTYPE] & cfg[`PMC_B_DIR]))
                                ? ~(stored[i] ^ cfg[`PMC_B_POL])
                                : (sum_term[i] ^ cfg[`PMC_B_POL]); // RULE1 RULE2 RULE13 RULE16
         assign next_pin_oe[i] = oe | observe_on; // RULE16
         // dual cells always give the pin; single cells choose
         assign next_array_fb[i] = (~dual & cfg[`PMC_B_FBSEL]) ? stored[i] : pin_in[i]; // RULE10 RULE22
         assign cfg_flat[i*`PMC_CFG_W +: `PMC_CFG_W] = cfg; // RULE23
      end
   endgenerate

   // storage elements and registered pin side
   always @(posedge ref_clk) begin
      if (!resetn) begin
         stored     <= 16'h0000; // RULE13
         pin_out    <= 16'h0000;
         pin_oe     <= 16'h0000;
         array_fb   <= 16'h0000;
         storage_fb <= 16'h0000;
      end else begin
         stored     <= next_stored;
         pin_out    <= next_pin_out;
         pin_oe     <= next_pin_oe;
         array_fb   <= next_array_fb;
         storage_fb <= stored; // RULE22 RULE5
      end
   end

   // security and preload value registers
   always @(posedge ref_clk) begin
      if (!resetn) begin
         secured       <= 1'b0;
         preload_value <= 16'h0000;
      end else begin
         if (erase_fire)
            secured <= 1'b0; // RULE18
         else if (secure_fire)
            secured <= 1'b1; // RULE17
         if (erase_fire) begin
            preload_value <= 16'h0000;
         end else if (wr_fire & (avs_address == `PMC_A_PRELOAD) & ~secured) begin
            if (avs_byteenable[0])
               preload_value[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
               preload_value[15:8] <= avs_writedata[15:8];
         end
      end
   end

   // read mux; locked part hides config and state
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (cfg_hit && !secured) begin
         rd_mux[8:0] = cfg_flat[cfg_idx*`PMC_CFG_W +: `PMC_CFG_W]; // RULE17
      end else if (avs_address == `PMC_A_CTRL || avs_address == `PMC_A_STATUS) begin
         rd_mux[0] = secured;
      end else if (avs_address == `PMC_A_PRELOAD && !secured) begin
         rd_mux[15:0] = preload_value;
      end else if (avs_address == `PMC_A_STORAGE && !secured) begin
         rd_mux[15:0] = stored;
      end else if (avs_address == `PMC_A_PINS) begin
         rd_mux[15:0] = pin_in;
      end
   end

   // one wait state: waitrequest drops for exactly one cycle
   always @(posedge ref_clk) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else if (bus_req && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= rd_mux;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// ### dv/pmc_board.sv
// Purpose: board logic on the far side of the i/o pins
// Assumes: ext changes every clock
// Notes: a pin no party drives shows ext, never a stale value
`default_nettype none
module pmc_board (
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   input  wire logic [15:0] ext,
   output wire logic [15:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // wire level from the cell drive and the board pattern
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// ### dv/pmc_macrocell_bank_checker.sv
// Purpose: bus timing and reset relations of the macrocell bank
// Assumes: one clock, sync active-low reset
// Notes: config state is hidden here, cell modes are judged in the bench
`default_nettype none
module pmc_chk (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] array_fb,
   input wire logic [15:0] storage_fb
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // a request is taken while waitrequest is still high
   wire logic take = avs_waitrequest && (avs_read || avs_write);
   answer_next_a: assert property (take |=> !avs_waitrequest) else $error("no answer after take");
   answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
   idle_quiet_a: assert property (avs_waitrequest && !take |=> avs_waitrequest) else $error("stray answer");
   reset_state_a: assert property (disable iff (1'b0) !resetn |=> avs_waitrequest && pin_oe == 16'h0 &&
      storage_fb == 16'h0) else $error("outputs not cleared");
   unmapped_zero_a: assert property (take && avs_read && avs_address > 8'h50 |=> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   dual_width_a: assert property (take && avs_read && avs_address < 8'h20 |=> avs_readdata[31:8] == 24'h0)
      else $error("dual cell has ninth cell");
   data_holds_a: assert property (!take |=> $stable(avs_readdata)) else $error("readdata moved");
   pin_feed_a: assert property ($past(resetn) |-> array_fb[7:0] == $past(pin_in[7:0]))
      else $error("dual cell pin feed wrong");
endmodule
`default_nettype wire

// ### dv/pmc_macrocell_bank_tb.sv
// Purpose: self-checking bench of the macrocell bank
// Assumes: reads are judged by a monitor from a queue of expectations
// Notes: cell 8 is the cell under test, a single feedback cell of bank 2
`default_nettype none
module pmc_macrocell_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable, bank_term_a, bank_term_b;
   logic        dedicated_timing_pin, shared_input_timing_pin, common_oe_pin, preset_term, reset_term;
   logic        preload_term, preload_hv, observe_term, observe_hv;
   logic [15:0] sum_term, pin_in, pin_out, pin_oe, array_fb, storage_fb, ext, v, s;
   int          num_errors, checks_done, cycles;
   logic [31:0] expq[$];
   pmc_macrocell_bank DUT (.*);
   pmc_board u_board (.*);
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_pin(input logic g, input logic e);
      cmp({31'h0, g}, {31'h0, e});
   endtask
   task automatic finish_test;
      // a read never answered leaves its note behind
      if (expq.size() != 0)
         num_errors++;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one bus access, held until waitrequest is seen low
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // let an edge pass so the next call never reassigns in this step
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b1, a, 32'h0);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // read data judged at the answering edge
   always @(posedge ref_clk) begin
      if (resetn && avs_read && avs_waitrequest === 1'b0 && expq.size() > 0)
         cmp(avs_readdata, expq.pop_front());
   end
   // board pattern and hang guard
   always @(posedge ref_clk) begin
      ext <= 16'($urandom);
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      {resetn, avs_read, avs_write, avs_address, avs_writedata, bank_term_a, bank_term_b} = '0;
      {dedicated_timing_pin, shared_input_timing_pin, common_oe_pin, preset_term, reset_term} = '0;
      {preload_term, preload_hv, observe_term, observe_hv, sum_term} = '0;
      avs_byteenable = 4'hf;
      void'($urandom(32'h1728));
      tick(8);
      resetn <= 1'b1;
      rd(8'h00, 32'hff);
      rd(8'h20, 32'h1ff);
      rd(8'h80, 32'h0);
      $display("reset state done");
      // every polarity and buffer code on a combinatorial output cell
      for (int i = 0; i < 8; i++) begin
         sum_term <= 16'($urandom);
         common_oe_pin <= 1'($urandom);
         bank_term_a <= 4'($urandom);
         bank_term_b <= 4'($urandom);
         bus(1'b0, 8'h20, 32'h13e | i[0] | (i[2] << 6) | (i[1] << 7));
         tick(3);
         cmp_pin(pin_out[8], sum_term[8] ^ i[0]);
         cmp_pin(pin_oe[8], i[2:1] == 3 ? common_oe_pin : i[2:1] == 2 ? bank_term_a[2] ^ bank_term_b[2] : i[1]);
      end
      $display("combinatorial modes done");
      // rising edge register on the dedicated pin, storage fed back
      bus(1'b0, 8'h20, 32'h1bc);
      v = 16'($urandom);
      sum_term <= v;
      dedicated_timing_pin <= 1'b1;
      tick(4);
      cmp_pin(pin_out[8], v[8]);
      // the element holds the inverted sum, the pin shows it true
      cmp_pin(array_fb[8], ~v[8]);
      cmp_pin(storage_fb[8], ~v[8]);
      sum_term <= ~v;
      dedicated_timing_pin <= 1'b0;
      shared_input_timing_pin <= 1'b1;
      tick(4);
      cmp_pin(pin_out[8], v[8]);
      $display("register mode done");
      bus(1'b0, 8'h44, {16'h0, v});
      preload_term <= 1'b1;
      tick(1);
      preload_term <= 1'b0;
      rd(8'h4c, {16'h0, v});
      bus(1'b0, 8'h40, 32'h1);
      rd(8'h48, 32'h1);
      rd(8'h20, 32'h0);
      rd(8'h4c, 32'h0);
      bus(1'b0, 8'h40, 32'h3);
      rd(8'h48, 32'h0);
      rd(8'h20, 32'h1ff);
      $display("preload and security done");
      reset_term <= 1'b1;
      tick(2);
      rd(8'h4c, 32'h0);
      preset_term <= 1'b1;
      tick(2);
      rd(8'h4c, 32'hffff);
      reset_term <= 1'b0;
      preset_term <= 1'b0;
      tick(2);
      $display("preset and reset done");
      // input latch on the shared pin, high gate, looped back pin
      bus(1'b0, 8'h20, 32'h180);
      s = 16'($urandom);
      sum_term <= s;
      tick(4);
      reset_term <= 1'b1;
      tick(2);
      reset_term <= 1'b0;
      shared_input_timing_pin <= 1'b0;
      tick(2);
      sum_term <= ~s;
      tick(4);
      cmp_pin(array_fb[8], s[8]);
      cmp_pin(storage_fb[8], s[8]);
      rd(8'h4c, {16'h0, s & 16'h0100});
      // cell 0 is a cleared active-low register behind a comb output
      observe_hv <= 1'b1;
      common_oe_pin <= 1'b0;
      sum_term <= 16'h0000;
      tick(3);
      cmp_pin(pin_out[0], 1'b0);
      cmp_pin(pin_oe[0], 1'b1);
      observe_hv <= 1'b0;
      tick(3);
      cmp_pin(pin_out[0], 1'b1);
      cmp_pin(pin_oe[0], 1'b0);
      // a locked part ignores observe and preload
      bus(1'b0, 8'h44, 32'hffff);
      bus(1'b0, 8'h40, 32'h1);
      observe_term <= 1'b1;
      preload_hv <= 1'b1;
      tick(3);
      cmp_pin(pin_oe[0], 1'b0);
      observe_term <= 1'b0;
      preload_hv <= 1'b0;
      bus(1'b0, 8'h40, 32'h3);
      rd(8'h4c, {16'h0, s & 16'h0100});
      $display("latch and observe done");
      finish_test();
   end
endmodule
bind pmc_macrocell_bank pmc_chk chk (.*);
`default_nettype wire
